// ---- mcd_axis.sv ----
`timescale 1ns/100ps
`default_nettype none
module mcd_axis
	import mcd_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Command from the decoder
	input wire logic cmd_valid,
	input wire mcd_kind_t cmd_kind,
	input wire logic [31:0] cmd_value,
	// Axis parameters to the ramp generator
	output mcd_axis_t st,
	output logic done
);
	typedef struct packed {
		mcd_phase_t phase;
		mcd_kind_t kind;
		logic [31:0] value;
		mcd_axis_t st;
		logic done;
	} mcd_axis_reg_t;

	mcd_axis_reg_t s;
	mcd_axis_reg_t next_s;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		case (s.phase)
			P_IDLE: begin
				if (cmd_valid) begin
					next_s.kind = cmd_kind;
					next_s.value = cmd_value;
					// Mode switches one edge before any target is touched
					next_s.st.vel_mode = 1'b1;
					next_s.st.soft_halt = (cmd_kind == K_HALT);
					next_s.phase = P_LOAD;
				end
			end
			P_LOAD: begin
				case (s.kind)
					K_POS: begin
						// Value is steps per second, passed unscaled
						next_s.st.target_vel = s.value;
						next_s.st.dir_pos = 1'b1;
					end
					K_NEG: begin
						next_s.st.target_vel = 32'(-s.value);
						next_s.st.dir_pos = 1'b0;
					end
					K_HALT: begin
						// Ramp generator sees zero target and decelerates
						next_s.st.target_speed = 32'h0;
						next_s.st.target_vel = 32'h0;
					end
					default: ;
				endcase
				next_s.done = 1'b1;
				next_s.phase = P_IDLE;
			end
			default: next_s.phase = P_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.phase <= P_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign st = s.st;
	assign done = s.done;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_spin_pos;
		(s.phase == P_IDLE && cmd_valid && cmd_kind == K_POS) |=>
			(st.vel_mode && s.phase == P_LOAD) ##1 (st.target_vel == $past(cmd_value, 2) && st.dir_pos);
	endproperty
	a_spin_pos: assert property (p_spin_pos) else $error("positive spin target wrong");

	property p_spin_neg;
		(s.phase == P_IDLE && cmd_valid && cmd_kind == K_NEG) |=>
			##1 (st.target_vel == 32'(-$past(cmd_value, 2)) && !st.dir_pos && done);
	endproperty
	a_spin_neg: assert property (p_spin_neg) else $error("negative spin target wrong");

	property p_mode_first;
		$changed(st.target_vel) |-> $past(st.vel_mode);
	endproperty
	a_mode_first: assert property (p_mode_first) else $error("target moved before mode");

	property p_halt;
		(s.phase == P_IDLE && cmd_valid && cmd_kind == K_HALT) |=>
			st.soft_halt ##1 (st.target_speed == 32'h0 && st.target_vel == 32'h0);
	endproperty
	a_halt: assert property (p_halt) else $error("soft halt not applied");
endmodule : mcd_axis
`default_nettype wire

// ---- mcd_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
module mcd_decoder
	import mcd_pkg::*;
#(
	parameter int NUM_AXES = 3
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Axis parameters
	// A net, since each axis instance drives its own element
	output wire mcd_axis_t [NUM_AXES-1:0] axis_state
);
	typedef struct packed {
		mcd_fsm_t fsm;
		mcd_frame_t frame;
		logic [7:0] mod_addr;
		logic [31:0] accu;
		logic [7:0] rep_status;
		logic [7:0] rep_instr;
		logic rep_valid;
		logic [7:0] awaddr;
		logic aw_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic w_got;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [NUM_AXES-1:0] cmd_valid;
		mcd_kind_t cmd_kind;
		logic [31:0] cmd_value;
	} mcd_top_st_t;

	mcd_top_st_t s;
	mcd_top_st_t next_s;
	logic chk_ours;
	logic chk_exec;
	mcd_kind_t chk_kind;
	logic [7:0] chk_status;
	logic [NUM_AXES-1:0] ax_done;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				r[8*b +: 8] = d[8*b +: 8];
		end
		return r;
	endfunction : wmerge

	function automatic logic [7:0] reg_addr(input logic [7:0] base, input int i);
		return 8'(base + 8'(4 * i));
	endfunction : reg_addr

	mcd_frame_check #(
		.NUM_AXES(NUM_AXES)
	) u_check (
		.frame(s.frame),
		.mod_addr(s.mod_addr),
		.ours(chk_ours),
		.exec(chk_exec),
		.kind(chk_kind),
		.status(chk_status)
	);

	for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
		mcd_axis u_axis (
			.aclk(aclk),
			.aresetn(aresetn),
			.cmd_valid(s.cmd_valid[g]),
			.cmd_kind(s.cmd_kind),
			.cmd_value(s.cmd_value),
			.st(axis_state[g]),
			.done(ax_done[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_s.cmd_valid = '0;
		if (awvalid && s.awready) begin
			next_s.awaddr = awaddr;
			next_s.aw_got = 1'b1;
		end
		if (wvalid && s.wready) begin
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
			next_s.w_got = 1'b1;
		end
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;
		if (s.aw_got && s.w_got) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.awaddr)
				// Frame bytes are frozen while a frame is being worked on
				ADDR_FRAME_HDR: begin
					if (s.fsm == S_IDLE)
						{next_s.frame.motor, next_s.frame.ftype, next_s.frame.instr,
							next_s.frame.addr} = wmerge({s.frame.motor, s.frame.ftype,
							s.frame.instr, s.frame.addr}, s.wdata, s.wstrb);
				end
				ADDR_FRAME_VAL: begin
					if (s.fsm == S_IDLE)
						next_s.frame.value = wmerge(s.frame.value, s.wdata, s.wstrb);
				end
				ADDR_FRAME_SUM: begin
					// The checksum byte completes the frame and launches it
					if (s.fsm == S_IDLE && s.wstrb[0]) begin
						next_s.frame.sum = s.wdata[7:0];
						next_s.fsm = S_CHECK;
					end
				end
				ADDR_MOD_ADDR: begin
					if (s.wstrb[0])
						next_s.mod_addr = s.wdata[7:0];
				end
				ADDR_ACCU: next_s.accu = wmerge(s.accu, s.wdata, s.wstrb);
				ADDR_REPLY: ;
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready = !next_s.w_got && !next_s.bvalid;

		////////////////////////////////////////////////////////////////////////
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		if (arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = 32'h0;
			case (araddr)
				ADDR_FRAME_HDR: next_s.rdata = {s.frame.motor, s.frame.ftype,
					s.frame.instr, s.frame.addr};
				ADDR_FRAME_VAL: next_s.rdata = s.frame.value;
				ADDR_FRAME_SUM: next_s.rdata = {24'h0, s.frame.sum};
				ADDR_REPLY: begin
					next_s.rdata = {14'h0, (s.fsm != S_IDLE), s.rep_valid, s.rep_instr,
						s.rep_status};
					// Reading consumes the reply; a new one this cycle wins below
					next_s.rep_valid = 1'b0;
				end
				ADDR_MOD_ADDR: next_s.rdata = {24'h0, s.mod_addr};
				ADDR_ACCU: next_s.rdata = s.accu;
				default: begin
					next_s.rresp = RESP_SLVERR;
					for (int i = 0; i < NUM_AXES; i++) begin
						if (araddr == reg_addr(ADDR_AXIS_CTRL, i)) begin
							next_s.rresp = RESP_OKAY;
							next_s.rdata = {29'h0, axis_state[i].soft_halt,
								axis_state[i].dir_pos, axis_state[i].vel_mode};
						end
						if (araddr == reg_addr(ADDR_AXIS_VEL, i)) begin
							next_s.rresp = RESP_OKAY;
							next_s.rdata = axis_state[i].target_vel;
						end
						if (araddr == reg_addr(ADDR_AXIS_SPEED, i)) begin
							next_s.rresp = RESP_OKAY;
							next_s.rdata = axis_state[i].target_speed;
						end
					end
				end
			endcase
		end
		next_s.arready = !next_s.rvalid;

		////////////////////////////////////////////////////////////////////////
		// Host frames never touch the accumulator; only software writes do
		case (s.fsm)
			S_IDLE: ;
			S_CHECK: begin
				if (!chk_ours) begin
					// Frame for another module: dropped without reply
					next_s.fsm = S_IDLE;
				end else if (chk_exec) begin
					for (int i = 0; i < NUM_AXES; i++) begin
						if (s.frame.motor == 8'(i))
							next_s.cmd_valid[i] = 1'b1;
					end
					next_s.cmd_kind = chk_kind;
					next_s.cmd_value = s.frame.value;
					next_s.fsm = S_WAIT;
				end else begin
					next_s.rep_valid = 1'b1;
					next_s.rep_status = chk_status;
					next_s.rep_instr = s.frame.instr;
					next_s.fsm = S_IDLE;
				end
			end
			S_WAIT: begin
				if (|ax_done) begin
					next_s.rep_valid = 1'b1;
					next_s.rep_status = STAT_OK;
					next_s.rep_instr = s.frame.instr;
					next_s.fsm = S_IDLE;
				end
			end
			default: next_s.fsm = S_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.fsm <= S_IDLE;
			s.mod_addr <= RST_MOD_ADDR;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_ok_reply;
		(s.fsm == S_CHECK && chk_ours && chk_exec) |-> ##[3:4] (s.rep_valid && s.rep_status == STAT_OK);
	endproperty
	a_ok_reply: assert property (p_ok_reply) else $error("no ok reply after command");

	property p_bad_sum;
		(s.fsm == S_CHECK && chk_ours && frame_sum(s.frame) != s.frame.sum) |=>
			(s.rep_valid && s.rep_status == STAT_BAD_SUM && s.cmd_valid == '0);
	endproperty
	a_bad_sum: assert property (p_bad_sum) else $error("bad checksum not rejected");

	property p_unknown;
		(s.fsm == S_CHECK && chk_ours && frame_sum(s.frame) == s.frame.sum
			&& !is_extended(s.frame.instr) && s.frame.instr > OP_SOFT_HALT) |=>
			(s.rep_status == STAT_BAD_CMD && s.fsm == S_IDLE);
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown opcode not rejected");

	property p_halt_xreg;
		(s.fsm == S_CHECK && chk_ours && s.frame.instr == OP_HALT_BY_XREG
			&& frame_sum(s.frame) == s.frame.sum) |=> (s.rep_status == STAT_NOT_DIRECT);
	endproperty
	a_halt_xreg: assert property (p_halt_xreg) else $error("x-register halt misread");

	property p_accu_hold;
		!(s.aw_got && s.w_got && s.awaddr == ADDR_ACCU) |=> $stable(s.accu);
	endproperty
	a_accu_hold: assert property (p_accu_hold) else $error("accumulator changed by frame");

	property p_bvalid_hold;
		(s.bvalid && !bready) |=> s.bvalid;
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
endmodule : mcd_decoder
`default_nettype wire

// ---- mcd_frame_check.sv ----
`timescale 1ns/100ps
`default_nettype none
module mcd_frame_check
	import mcd_pkg::*;
#(
	parameter int NUM_AXES = 3
) (
	// Frame under test
	input wire mcd_frame_t frame,
	input wire logic [7:0] mod_addr,
	// Verdict
	output logic ours,
	output logic exec,
	output mcd_kind_t kind,
	output logic [7:0] status
);
	always_comb begin
		ours = (frame.addr == mod_addr);
		exec = 1'b0;
		status = STAT_OK;
		case (frame.instr)
			OP_SPIN_POS: kind = K_POS;
			OP_SPIN_NEG: kind = K_NEG;
			OP_SOFT_HALT: kind = K_HALT;
			default: kind = K_NONE;
		endcase
		if (frame_sum(frame) != frame.sum)
			status = STAT_BAD_SUM;
		else if (is_extended(frame.instr))
			status = STAT_NOT_DIRECT;
		else if (kind == K_NONE)
			status = STAT_BAD_CMD;
		else if (frame.ftype != 8'h00)
			status = STAT_BAD_TYPE;
		else if (frame.motor >= 8'(NUM_AXES))
			status = STAT_BAD_VALUE;
		else if (kind == K_HALT && frame.value != 32'h0)
			status = STAT_BAD_VALUE;
		else
			exec = 1'b1;
	end
endmodule : mcd_frame_check
`default_nettype wire

// ---- mcd_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module mcd_host
	import mcd_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hf;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One edge first, so a strobe dropped by the last call is never raised in the same step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	////////////////////////////////////////////////////////////////////////////////
	// Frame goes out header, value, then checksum; the checksum write launches it
	task automatic send(input mcd_frame_t f, output logic [15:0] status);
		logic [1:0] r;
		logic [31:0] d;
		int n;
		wr(ADDR_FRAME_HDR, {f.motor, f.ftype, f.instr, f.addr}, r);
		wr(ADDR_FRAME_VAL, f.value, r);
		wr(ADDR_FRAME_SUM, {24'h0, f.sum}, r);
		n = 0;
		do begin
			rd(ADDR_REPLY, d, r);
			n++;
		end while (d[16] !== 1'b1 && n < 20);
		status = (d[16] === 1'b1) ? d[15:0] : 16'h0000;
	endtask : send
endmodule : mcd_host
`default_nettype wire

// ---- mcd_pkg.sv ----
`default_nettype none
package mcd_pkg;
	// Instruction numbers of the basic motion commands
	localparam logic [7:0] OP_SPIN_POS = 8'h01;
	localparam logic [7:0] OP_SPIN_NEG = 8'h02;
	localparam logic [7:0] OP_SOFT_HALT = 8'h03;
	// Extended set, recognised only
	localparam logic [7:0] OP_AXP_WR_X = 8'h10;
	localparam logic [7:0] OP_ACCU_AXP_X = 8'h12;
	localparam logic [7:0] OP_ARITH_FIRST = 8'h28;
	localparam logic [7:0] OP_GOTO_ACCU_X = 8'h2f;
	localparam logic [7:0] OP_RESTART = 8'h30;
	localparam logic [7:0] OP_DEC_BRANCH = 8'h31;
	localparam logic [7:0] OP_SPIN_ACCU_FIRST = 8'h32;
	localparam logic [7:0] OP_HALT_BY_XREG = 8'h36;
	localparam logic [7:0] OP_IDX_VAR_LAST = 8'h39;
	localparam logic [7:0] OP_COND_CALL = 8'h50;
	// Reply status codes
	localparam logic [7:0] STAT_OK = 8'h64;
	localparam logic [7:0] STAT_BAD_SUM = 8'h01;
	localparam logic [7:0] STAT_BAD_CMD = 8'h02;
	localparam logic [7:0] STAT_BAD_TYPE = 8'h03;
	localparam logic [7:0] STAT_BAD_VALUE = 8'h04;
	localparam logic [7:0] STAT_NOT_DIRECT = 8'h06;
	// Register byte offsets
	localparam logic [7:0] ADDR_FRAME_HDR = 8'h00;
	localparam logic [7:0] ADDR_FRAME_VAL = 8'h04;
	localparam logic [7:0] ADDR_FRAME_SUM = 8'h08;
	localparam logic [7:0] ADDR_REPLY = 8'h0c;
	localparam logic [7:0] ADDR_MOD_ADDR = 8'h10;
	localparam logic [7:0] ADDR_ACCU = 8'h14;
	localparam logic [7:0] ADDR_AXIS_CTRL = 8'h20;
	localparam logic [7:0] ADDR_AXIS_VEL = 8'h30;
	localparam logic [7:0] ADDR_AXIS_SPEED = 8'h40;
	localparam logic [7:0] RST_MOD_ADDR = 8'h01;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {K_NONE, K_POS, K_NEG, K_HALT} mcd_kind_t;
	typedef enum logic [2:0] {S_IDLE = 3'b001, S_CHECK = 3'b010, S_WAIT = 3'b100} mcd_fsm_t;
	typedef enum logic [1:0] {P_IDLE = 2'b01, P_LOAD = 2'b10} mcd_phase_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] instr;
		logic [7:0] ftype;
		logic [7:0] motor;
		logic [31:0] value;
		logic [7:0] sum;
	} mcd_frame_t;

	typedef struct packed {
		logic vel_mode;
		logic soft_halt;
		logic dir_pos;
		logic [31:0] target_speed;
		logic [31:0] target_vel;
	} mcd_axis_t;

	function automatic logic [7:0] frame_sum(input mcd_frame_t f);
		return 8'(f.addr + f.instr + f.ftype + f.motor + f.value[31:24]
			+ f.value[23:16] + f.value[15:8] + f.value[7:0]);
	endfunction : frame_sum

	function automatic logic is_extended(input logic [7:0] op);
		return (op >= OP_AXP_WR_X && op <= OP_ACCU_AXP_X)
			|| (op >= OP_ARITH_FIRST && op <= OP_IDX_VAR_LAST) || op == OP_COND_CALL;
	endfunction : is_extended
endpackage : mcd_pkg
`default_nettype wire

// ---- motion_command_decoder_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module motion_command_decoder_bench
	import mcd_pkg::*;
;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d, accu;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	mcd_axis_t [2:0] axis_state;
	mcd_axis_t model [3];
	logic [31:0] prev_tv [3];
	logic prev_vm [3];
	int bad_count, compares, seed;
	logic [7:0] my_addr;
	mcd_frame_t f;

	mcd_decoder #(.NUM_AXES(3)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .axis_state(axis_state));
	mcd_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask : chk

	task automatic results();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	function automatic mcd_frame_t mk(input logic [7:0] op, input logic [7:0] m,
		input logic [31:0] v);
		return '{addr: 8'h01, instr: op, ftype: 8'h00, motor: m, value: v, sum: 8'h00};
	endfunction : mk

	function automatic logic [7:0] fsum(input mcd_frame_t x);
		return 8'(x.addr + x.instr + x.ftype + x.motor + x.value[31:24] + x.value[23:16]
			+ x.value[15:8] + x.value[7:0]);
	endfunction : fsum

	// Priority of the verdicts follows the hand-over order
	function automatic logic [7:0] exp_stat(input mcd_frame_t x, input logic sum_ok);
		if (x.addr !== my_addr)
			return 8'h00;
		if (!sum_ok)
			return STAT_BAD_SUM;
		if ((x.instr >= 8'h10 && x.instr <= 8'h12) || (x.instr >= 8'h28 && x.instr <= 8'h39)
			|| x.instr == 8'h50)
			return STAT_NOT_DIRECT;
		if (x.instr < 8'h01 || x.instr > 8'h03)
			return STAT_BAD_CMD;
		if (x.ftype != 8'h00)
			return STAT_BAD_TYPE;
		if (x.motor >= 8'h03)
			return STAT_BAD_VALUE;
		if (x.instr == 8'h03 && x.value != 32'h0)
			return STAT_BAD_VALUE;
		return 8'h64;
	endfunction : exp_stat

	task automatic run(input mcd_frame_t x, input logic sum_ok);
		logic [15:0] st;
		logic [7:0] e;
		x.sum = fsum(x) ^ {7'h0, !sum_ok};
		e = exp_stat(x, sum_ok);
		host.send(x, st);
		chk(st[7:0] === e, "reply status");
		if (e !== 8'h00)
			chk(st[15:8] === x.instr, "reply instruction");
		if (e === 8'h64) begin
			model[x.motor].vel_mode = 1'b1;
			model[x.motor].soft_halt = (x.instr == 8'h03);
			if (x.instr == 8'h03) begin
				model[x.motor].target_speed = 32'h0;
				model[x.motor].target_vel = 32'h0;
			end else begin
				model[x.motor].dir_pos = (x.instr == 8'h01);
				model[x.motor].target_vel = (x.instr == 8'h01) ? x.value : -x.value;
			end
		end
		for (int i = 0; i < 3; i++) begin
			chk(axis_state[i].vel_mode === model[i].vel_mode
				&& axis_state[i].soft_halt === model[i].soft_halt
				&& axis_state[i].target_vel === model[i].target_vel
				&& axis_state[i].target_speed === model[i].target_speed, "axis state");
			if (!model[i].soft_halt)
				chk(axis_state[i].dir_pos === model[i].dir_pos, "direction");
		end
	endtask : run

	////////////////////////////////////////////////////////////////////////////////
	// A velocity change is only legal once velocity mode already stood a cycle earlier
	always @(posedge aclk) begin
		for (int i = 0; i < 3; i++) begin
			if (aresetn && axis_state[i].target_vel !== prev_tv[i])
				chk(prev_vm[i] === 1'b1, "mode before velocity");
			prev_tv[i] <= axis_state[i].target_vel;
			prev_vm[i] <= axis_state[i].vel_mode;
		end
	end

	initial begin
		repeat (40000) @(posedge aclk);
		bad_count++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		results();
	end

	initial begin
		seed = 26;
		my_addr = RST_MOD_ADDR;
		aresetn = 1'b0;
		for (int i = 0; i < 3; i++)
			model[i] = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		host.rd(ADDR_MOD_ADDR, d, r);
		chk(d[7:0] === RST_MOD_ADDR && r === RESP_OKAY, "module address reset");
		accu = $random(seed);
		host.wr(ADDR_ACCU, accu, r);
		chk(fsum(mk(8'h01, 8'h00, 32'h0000c800)) === 8'hca, "sum right");
		chk(fsum(mk(8'h02, 8'h00, 32'h0000c800)) === 8'hcb, "sum left");
		chk(fsum(mk(8'h03, 8'h00, 32'h0)) === 8'h04, "sum halt");
		run(mk(8'h01, 8'h00, 32'h0000c800), 1'b1);
		run(mk(8'h02, 8'h02, 32'h0000c800), 1'b1);
		run(mk(8'h03, 8'h00, 32'h0), 1'b1);
		run(mk(8'h01, 8'h01, 32'h80000000), 1'b1);
		run(mk(8'h03, 8'h03, 32'h0), 1'b1);
		f = mk(8'h01, 8'h00, 32'h1);
		f.addr = 8'h02;
		run(f, 1'b1);
		// Same frame again once the module answers to that address
		host.wr(ADDR_MOD_ADDR, 32'h00000002, r);
		chk(r === RESP_OKAY, "module address write");
		my_addr = 8'h02;
		run(f, 1'b1);
		host.wr(ADDR_MOD_ADDR, {24'h000000, RST_MOD_ADDR}, r);
		my_addr = RST_MOD_ADDR;
		host.rd(ADDR_AXIS_VEL, d, r);
		chk(d === model[0].target_vel && r === RESP_OKAY, "velocity register");
		host.rd(ADDR_AXIS_CTRL, d, r);
		chk(d === {29'h00000000, model[0].soft_halt, model[0].dir_pos, model[0].vel_mode}
			&& r === RESP_OKAY, "control register");
		$display("test corners done");
		for (int c = 0; c < 256; c++)
			run(mk(8'(c), 8'($unsigned($random(seed)) % 3), $random(seed)), 1'b1);
		$display("test opcode sweep done");
		repeat (60) begin
			f = mk(8'($unsigned($random(seed)) % 3 + 1), 8'($unsigned($random(seed)) % 4),
				$random(seed));
			f.ftype = ($unsigned($random(seed)) % 8 == 0) ? 8'h01 : 8'h00;
			if (f.instr == 8'h03 && $random(seed) % 2 == 0)
				f.value = 32'h0;
			run(f, ($unsigned($random(seed)) % 8) != 0);
		end
		$display("test random done");
		host.rd(8'hfc, d, r);
		chk(r === RESP_SLVERR && d === 32'h0, "unmapped read");
		host.wr(8'hfc, 32'h1, r);
		chk(r === RESP_SLVERR, "unmapped write");
		host.rd(ADDR_ACCU, d, r);
		chk(d === accu, "accumulator kept");
		$display("test registers done");
		results();
	end
endmodule : motion_command_decoder_bench
`default_nettype wire
